/* File: rtl/sim_pkg.sv */
// Constants for the serial-IRQ slot to host interrupt routing table.
// Assumes the configuration portal upstream has already resolved index and logical device.
package sim_pkg;

  // Logical device that holds the routing table.
  localparam logic [7:0] SIM_LDN          = 8'h00;
  // Number of routing registers.
  localparam int         SIM_NUM_ROUTES   = 8;
  // Route value that leaves a slot unbound.
  localparam logic [7:0] SIM_ROUTE_NONE   = 8'hFF;
  // Read data for an index that is not part of the table.
  localparam logic [7:0] SIM_RDATA_NONE   = 8'h00;

  // Configuration index of each routing register, slot 6 first.
  localparam logic [7:0] SIM_IDX_SLOT6    = 8'hAF;
  localparam logic [7:0] SIM_IDX_SLOT7    = 8'hB0;
  localparam logic [7:0] SIM_IDX_SLOT8    = 8'hB1;
  localparam logic [7:0] SIM_IDX_SLOT10   = 8'hB2;
  localparam logic [7:0] SIM_IDX_SLOT11   = 8'hB3;
  localparam logic [7:0] SIM_IDX_SLOT12   = 8'hB4;
  localparam logic [7:0] SIM_IDX_SLOT13   = 8'hB5;
  localparam logic [7:0] SIM_IDX_SLOT15   = 8'hB6;

  // Platform reset defaults: the legacy interrupt of each slot.
  localparam logic [7:0] SIM_RST_SLOT6    = 8'h05;
  localparam logic [7:0] SIM_RST_SLOT7    = 8'h06;
  localparam logic [7:0] SIM_RST_SLOT8    = 8'h07;
  localparam logic [7:0] SIM_RST_SLOT10   = 8'h09;
  localparam logic [7:0] SIM_RST_SLOT11   = 8'h0A;
  localparam logic [7:0] SIM_RST_SLOT12   = 8'h0B;
  localparam logic [7:0] SIM_RST_SLOT13   = 8'h0C;
  localparam logic [7:0] SIM_RST_SLOT15   = 8'h0E;

  // Serial-IRQ slot number served by each register.
  localparam logic [4:0] SIM_SLOT6        = 5'h06;
  localparam logic [4:0] SIM_SLOT7        = 5'h07;
  localparam logic [4:0] SIM_SLOT8        = 5'h08;
  localparam logic [4:0] SIM_SLOT10       = 5'h0A;
  localparam logic [4:0] SIM_SLOT11       = 5'h0B;
  localparam logic [4:0] SIM_SLOT12       = 5'h0C;
  localparam logic [4:0] SIM_SLOT13       = 5'h0D;
  localparam logic [4:0] SIM_SLOT15       = 5'h0F;

  // Tables indexed by register number, built from the names above.
  localparam logic [7:0] SIM_IDX_TAB [SIM_NUM_ROUTES] = '{SIM_IDX_SLOT6, SIM_IDX_SLOT7, SIM_IDX_SLOT8,
    SIM_IDX_SLOT10, SIM_IDX_SLOT11, SIM_IDX_SLOT12, SIM_IDX_SLOT13, SIM_IDX_SLOT15};
  localparam logic [7:0] SIM_RST_TAB [SIM_NUM_ROUTES] = '{SIM_RST_SLOT6, SIM_RST_SLOT7, SIM_RST_SLOT8,
    SIM_RST_SLOT10, SIM_RST_SLOT11, SIM_RST_SLOT12, SIM_RST_SLOT13, SIM_RST_SLOT15};
  localparam logic [4:0] SIM_SLOT_TAB [SIM_NUM_ROUTES] = '{SIM_SLOT6, SIM_SLOT7, SIM_SLOT8,
    SIM_SLOT10, SIM_SLOT11, SIM_SLOT12, SIM_SLOT13, SIM_SLOT15};

  // Forwarding state machine, one-hot.
  typedef enum logic [1:0] {
    SIM_ST_IDLE = 2'b01,
    SIM_ST_SEND = 2'b10
  } sim_state_type;

endpackage : sim_pkg

/* File: rtl/sim_route_reg.sv */
// One eight-bit routing register with a fixed platform reset value.
// Assumes a single write strobe per cycle from the index decode of the parent.
`timescale 1ns/1ps
module sim_route_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  // Clock and platform reset.
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Write port.
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  // Stored value.
  output logic      [7:0] route_q
);

  // Holds the last written value; platform reset restores the legacy default.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      route_q <= RESET_VALUE;
    else if (wr_en)
      route_q <= wr_data;
  end

endmodule : sim_route_reg

/* File: rtl/sim_slot_irq_map.sv */
// Serial-IRQ slot routing table and virtual-wire interrupt forwarder.
// Assumes the index/data portal upstream presents resolved config accesses, and that
// the serial-IRQ engine delivers one decoded slot event at a time.
//
// Summary of operation
// - Index AFh of device 00h routes slot 6, resets to 05h.
// - Index B0h of device 00h routes slot 7, resets to 06h.
// - Index B1h of device 00h routes slot 8, resets to 07h.
// - Index B2h of device 00h routes slot 10, resets to 09h.
// - Index B3h of device 00h routes slot 11, resets to 0Ah.
// - Index B4h of device 00h routes slot 12, resets to 0Bh.
// - Index B5h of device 00h routes slot 13, resets to 0Ch.
// - Index B6h of device 00h routes slot 15, resets to 0Eh.
// - A route value of FFh unbinds the slot; its activity goes nowhere.
// - Any other route value is the host interrupt number the slot is forwarded as.
`timescale 1ns/1ps
module sim_slot_irq_map
  import sim_pkg::*;
(
  // Clock and platform reset.
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Configuration access, already decoded from the index/data portal.
  input  wire logic [7:0] cfg_ldn,
  input  wire logic [7:0] cfg_index,
  input  wire logic       cfg_wr,
  input  wire logic       cfg_rd,
  input  wire logic [7:0] cfg_wdata,
  output logic      [7:0] cfg_rdata,
  output logic            cfg_rvalid,
  // Decoded serial-IRQ slot events.
  input  wire logic       sirq_evt,
  input  wire logic [4:0] sirq_slot,
  input  wire logic       sirq_level,
  output logic            sirq_ready,
  // Virtual-wire interrupt report toward the host.
  output logic            vw_valid,
  input  wire logic       vw_ready,
  output logic      [7:0] vw_irq,
  output logic            vw_level
);

  logic [7:0]          route_q   [SIM_NUM_ROUTES];
  logic [SIM_NUM_ROUTES-1:0] idx_hit;
  logic [SIM_NUM_ROUTES-1:0] slot_hit;
  logic [SIM_NUM_ROUTES-1:0] wr_en;
  logic [SIM_NUM_ROUTES-1:0] lvl_r;
  logic [SIM_NUM_ROUTES-1:0] lvl_nxt;
  logic                ldn_sel;
  logic                any_idx;
  logic                any_slot;
  logic [7:0]          rd_sel;
  logic [7:0]          slot_route;
  logic                slot_lvl;
  logic                evt_take;
  logic                evt_fwd;
  sim_state_type       state_r;
  sim_state_type       state_nxt;
  logic [7:0]          rdata_r;
  logic                rvalid_r;
  logic [7:0]          irq_r;
  logic                level_r;

  // Address decode: only device 00h selects the table, so other devices cannot alias it.
  assign ldn_sel = (cfg_ldn == SIM_LDN);

  // One register per slot; the reset value tables keep the legacy assignments.
  genvar g;
  generate
    for (g = 0; g < SIM_NUM_ROUTES; g++)
    begin : g_route
      assign idx_hit[g]  = ldn_sel && (cfg_index == SIM_IDX_TAB[g]);
      assign slot_hit[g] = (sirq_slot == SIM_SLOT_TAB[g]);
      assign wr_en[g]    = cfg_wr && idx_hit[g];
      sim_route_reg #(
        .RESET_VALUE (SIM_RST_TAB[g])
      ) u_reg (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .wr_en       (wr_en[g]),
        .wr_data     (cfg_wdata),
        .route_q     (route_q[g])
      );
    end
  endgenerate

  // Select the addressed register and the route of the arriving slot.
  always_comb
  begin
    rd_sel     = SIM_RDATA_NONE;
    slot_route = SIM_ROUTE_NONE;
    slot_lvl   = 1'b0;
    for (int i = 0; i < SIM_NUM_ROUTES; i++)
    begin
      if (idx_hit[i])
        rd_sel = route_q[i];
      if (slot_hit[i])
      begin
        slot_route = route_q[i];
        slot_lvl   = lvl_r[i];
      end
    end
  end

  assign any_idx  = |idx_hit;
  assign any_slot = |slot_hit;

  // An event is taken only while idle; a level change in a bound slot is forwarded.
  assign sirq_ready = (state_r == SIM_ST_IDLE);
  assign evt_take   = sirq_evt && sirq_ready;
  assign evt_fwd    = evt_take && any_slot && (slot_route != SIM_ROUTE_NONE)
                      && (sirq_level != slot_lvl);
  // Levels track even for unbound slots, so a later binding reports only real changes.
  assign lvl_nxt    = evt_take ? ((lvl_r & ~slot_hit) | (slot_hit & {SIM_NUM_ROUTES{sirq_level}})) : lvl_r;

  // Forwarder stays in SEND until the host side accepts the report.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      SIM_ST_IDLE: if (evt_fwd) state_nxt = SIM_ST_SEND;
      SIM_ST_SEND: if (vw_ready) state_nxt = SIM_ST_IDLE;
      default:     state_nxt = SIM_ST_IDLE;
    endcase
  end

  // State and per-slot level memory.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= SIM_ST_IDLE;
      lvl_r   <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      lvl_r   <= lvl_nxt;
    end
  end

  // Report payload; the route value itself is the host interrupt number.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_r   <= SIM_ROUTE_NONE;
      level_r <= 1'b0;
    end
    else if (evt_fwd)
    begin
      irq_r   <= slot_route;
      level_r <= sirq_level;
    end
  end

  // Read data comes one cycle after the strobe; unknown indexes read as zero.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_r  <= SIM_RDATA_NONE;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= cfg_rd;
      if (cfg_rd)
        rdata_r <= rd_sel;
    end
  end

  assign cfg_rdata  = rdata_r;
  assign cfg_rvalid = rvalid_r;
  assign vw_valid   = (state_r == SIM_ST_SEND);
  assign vw_irq     = irq_r;
  assign vw_level   = level_r;

  // Checks on the routing table and the forwarder.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  generate
    for (g = 0; g < SIM_NUM_ROUTES; g++)
    begin : g_chk
      chk_reset_default_value: assert property ($rose(rst_n) |-> route_q[g] == SIM_RST_TAB[g])
        else $error("Route register left reset with the wrong default.");
      chk_write_updates_route: assert property (wr_en[g] |=> route_q[g] == $past(cfg_wdata))
        else $error("Route register did not take the written value.");
      // Compared against the register itself, so a broken read multiplexer cannot hide.
      chk_readback_matches_reg: assert property (cfg_rd && idx_hit[g]
        |=> cfg_rvalid && cfg_rdata == $past(route_q[g]))
        else $error("Read returned a value other than the stored route.");
    end
  endgenerate

  chk_unmapped_index_zero: assert property (cfg_rd && !any_idx |=> cfg_rdata == SIM_RDATA_NONE)
    else $error("Read of a foreign index did not return zero.");
  chk_unbound_slot_silent: assert property (evt_take && slot_route == SIM_ROUTE_NONE |=> !vw_valid)
    else $error("Unbound slot produced a host report.");
  chk_forward_irq_number: assert property (evt_fwd |=> vw_valid && vw_irq == $past(slot_route))
    else $error("Report carried the wrong interrupt number.");
  chk_level_change_reported: assert property (evt_take && any_slot && slot_route != SIM_ROUTE_NONE
    && sirq_level != slot_lvl |=> vw_valid && vw_level == $past(sirq_level))
    else $error("Level change in a bound slot was not reported.");
  chk_report_held_ready: assert property (vw_valid && !vw_ready |=> vw_valid && $stable(vw_irq) && $stable(vw_level))
    else $error("Report dropped before the host accepted it.");
  // A refused event must leave no trace, or a later real change would go unreported.
  chk_busy_refuses_event: assert property (sirq_evt && !sirq_ready |=> $stable(lvl_r))
    else $error("Event accepted while a report was pending.");
  chk_report_drops_after: assert property (vw_valid && vw_ready |=> !vw_valid)
    else $error("Report stayed up after the host accepted it.");

  cov_bound_report:   cover property (evt_fwd ##1 vw_valid ##[1:4] vw_ready);
  cov_unbind_write:   cover property (cfg_wr && any_idx && cfg_wdata == SIM_ROUTE_NONE);
  cov_remapped_route: cover property (evt_fwd && slot_route != SIM_RST_TAB[0]);
  // Falling levels and refused events are the paths that ordinary traffic seldom reaches.
  cov_level_fall:     cover property (evt_fwd && !sirq_level);
  cov_refused_event:  cover property (sirq_evt && !sirq_ready);

endmodule : sim_slot_irq_map

/* File: tb/sim_vw_host_model.sv */
// Host-side receiver of virtual-wire interrupt reports, answering promptly or slowly.
// Assumes the same core clock and platform reset as the routing table.
`timescale 1ns/1ps
module sim_vw_host_model (
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Pace control from the bench.
  input  wire logic       slow,
  // Report interface.
  input  wire logic       vw_valid,
  input  wire logic [7:0] vw_irq,
  input  wire logic       vw_level,
  output logic            vw_ready,
  // Record of accepted reports.
  output logic      [7:0] rep_cnt,
  output logic      [7:0] last_irq,
  output logic            last_level
);
  logic [1:0] wait_cnt;

  // A slow host lets a report wait two extra cycles, so the hold of each field is exercised.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vw_ready   <= 1'b0;
      wait_cnt   <= 2'd0;
      rep_cnt    <= 8'h00;
      last_irq   <= 8'h00;
      last_level <= 1'b0;
    end
    else
    begin
      vw_ready <= 1'b0;
      if (vw_valid && !vw_ready)
      begin
        wait_cnt <= wait_cnt + 2'd1;
        vw_ready <= (wait_cnt >= (slow ? 2'd2 : 2'd0));
      end
      if (vw_valid && vw_ready)
      begin
        rep_cnt    <= rep_cnt + 8'h01;
        last_irq   <= vw_irq;
        last_level <= vw_level;
        wait_cnt   <= 2'd0;
      end
    end
  end
endmodule : sim_vw_host_model

/* File: tb/tb_sim_slot_irq_map.sv */
// Self-checking bench for the slot routing table and its report forwarder.
// Assumes resolved config accesses are presented directly, as the portal lies upstream.
`timescale 1ns/1ps
module tb_sim_slot_irq_map;
  import sim_pkg::*;
  logic       core_clk, rst_n, cfg_wr, cfg_rd, sirq_evt, sirq_level, slow;
  logic [7:0] cfg_ldn, cfg_index, cfg_wdata, rd;
  logic [4:0] sirq_slot;
  wire  [7:0] cfg_rdata, vw_irq, rep_cnt, last_irq;
  wire        cfg_rvalid, sirq_ready, vw_valid, vw_ready, vw_level, last_level;
  int         fails, total_checks;
  logic [7:0] rst_exp [8] = '{8'h05, 8'h06, 8'h07, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0E};

  sim_slot_irq_map sim_slot_irq_map_i (.core_clk(core_clk), .rst_n(rst_n), .cfg_ldn(cfg_ldn),
    .cfg_index(cfg_index), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .sirq_evt(sirq_evt), .sirq_slot(sirq_slot), .sirq_level(sirq_level),
    .sirq_ready(sirq_ready), .vw_valid(vw_valid), .vw_ready(vw_ready), .vw_irq(vw_irq), .vw_level(vw_level));
  sim_vw_host_model sim_vw_host_model_i (.core_clk(core_clk), .rst_n(rst_n), .slow(slow),
    .vw_valid(vw_valid), .vw_irq(vw_irq), .vw_level(vw_level), .vw_ready(vw_ready),
    .rep_cnt(rep_cnt), .last_irq(last_irq), .last_level(last_level));

  // Free-running 50 MHz clock.
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // A one-cycle write strobe; the strobe drops before the next call can raise it.
  task automatic cfg_write(input logic [7:0] ldn, input logic [7:0] idx, input logic [7:0] dat);
    @(posedge core_clk);
    cfg_ldn <= ldn;
    cfg_index <= idx;
    cfg_wdata <= dat;
    cfg_wr <= 1'b1;
    @(posedge core_clk);
    cfg_wr <= 1'b0;
  endtask : cfg_write

  // The valid flag stands for one cycle only, so the answer is taken just after the edge that follows the strobe.
  task automatic cfg_read(input logic [7:0] ldn, input logic [7:0] idx);
    @(posedge core_clk);
    cfg_ldn <= ldn;
    cfg_index <= idx;
    cfg_rd <= 1'b1;
    @(posedge core_clk);
    cfg_rd <= 1'b0;
    #1;
    chk({7'h00, cfg_rvalid}, 8'h01);
    rd = cfg_rdata;
  endtask : cfg_read

  // One slot event, then enough cycles for even a slow host to accept a report.
  task automatic sirq(input logic [4:0] s, input logic lv, input logic [7:0] n_exp, input logic [7:0] irq_exp);
    @(posedge core_clk);
    #1;
    chk({7'h00, sirq_ready}, 8'h01);
    @(posedge core_clk);
    sirq_slot <= s;
    sirq_level <= lv;
    sirq_evt <= 1'b1;
    @(posedge core_clk);
    sirq_evt <= 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    chk(rep_cnt, n_exp);
    chk(last_irq, irq_exp);
  endtask : sirq

  // Watchdog: the whole sequence needs well under a thousand cycles.
  initial
  begin
    #200000;
    fails++;
    summarize();
  end

  // Main sequence.
  initial
  begin
    {cfg_wr, cfg_rd, sirq_evt, sirq_level, slow, rst_n} = 6'b0;
    {cfg_ldn, cfg_index, cfg_wdata, rd} = 32'h0000_0000;
    sirq_slot = 5'h00;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      cfg_read(8'h00, SIM_IDX_TAB[i]);
      chk(rd, rst_exp[i]);
    end
    $display("test reset_defaults done");
    for (int i = 0; i < 8; i++)
    begin
      cfg_write(8'h00, SIM_IDX_TAB[i], 8'h20 + 8'(i));
      cfg_write(8'h01, SIM_IDX_TAB[i], 8'h55);
    end
    cfg_write(8'h00, 8'hB7, 8'h33);
    for (int i = 0; i < 8; i++)
    begin
      cfg_read(8'h00, SIM_IDX_TAB[i]);
      chk(rd, 8'h20 + 8'(i));
    end
    cfg_read(8'h00, 8'hB7);
    chk(rd, 8'h00);
    $display("test write_readback done");
    // A second platform reset in mid-run must bring the defaults back.
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    cfg_read(8'h00, SIM_IDX_TAB[0]);
    chk(rd, 8'h05);
    sirq(5'd6, 1'b1, 8'h01, 8'h05);
    chk({7'h00, last_level}, 8'h01);
    sirq(5'd6, 1'b1, 8'h01, 8'h05);
    slow <= 1'b1;
    cfg_write(8'h00, SIM_IDX_TAB[3], 8'h15);
    sirq(5'd10, 1'b1, 8'h02, 8'h15);
    cfg_write(8'h00, SIM_IDX_TAB[0], 8'hFF);
    sirq(5'd6, 1'b0, 8'h02, 8'h15);
    sirq(5'd9, 1'b1, 8'h02, 8'h15);
    sirq(5'd15, 1'b1, 8'h03, 8'h0E);
    sirq(5'd15, 1'b0, 8'h04, 8'h0E);
    chk({7'h00, last_level}, 8'h00);
    // An event held into the busy cycle is lost and must not record its level.
    @(posedge core_clk);
    sirq_slot  <= 5'd7;
    sirq_level <= 1'b1;
    sirq_evt   <= 1'b1;
    @(posedge core_clk);
    sirq_slot  <= 5'd8;
    @(posedge core_clk);
    sirq_evt   <= 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    chk(rep_cnt, 8'h05);
    chk(last_irq, 8'h06);
    sirq(5'd8, 1'b1, 8'h06, 8'h07);
    $display("test forwarding done");
    summarize();
  end
endmodule : tb_sim_slot_irq_map
